// [verilog/adcc_pkg.sv]
`default_nettype none
package adcc_pkg;
  // -------------------------------------------------------------------
  // configuration register
  // -------------------------------------------------------------------
  localparam logic [7:0]  CFG_OFS     = 8'h90;
  localparam logic [3:0]  ADDR_PREFIX = CFG_OFS[7:4];
  localparam logic [7:0]  CFG_RST     = 8'h80;
  localparam int          FLAG_BIT    = 7;
  localparam int          SC_BIT      = 4;
  localparam int          RATE_HI_BIT = 3;
  localparam int          RATE_LO_BIT = 2;
  localparam int          GAIN_HI_BIT = 1;
  localparam int          GAIN_LO_BIT = 0;
  localparam int          CFG_LOW_W   = 5;
  localparam logic [1:0]  CFG_PAD     = 2'h0;
  // -------------------------------------------------------------------
  // result register and limits per rate
  // -------------------------------------------------------------------
  localparam logic [15:0] RES_RST     = 16'h0000;
  localparam logic [1:0]  RATE_480    = 2'h0;
  localparam logic [1:0]  RATE_240    = 2'h1;
  localparam logic [1:0]  RATE_60     = 2'h2;
  localparam logic [1:0]  RATE_30     = 2'h3;
  localparam logic [15:0] LIM_480     = 16'h07FF;
  localparam logic [15:0] LIM_240     = 16'h0FFF;
  localparam logic [15:0] LIM_60      = 16'h3FFF;
  localparam logic [15:0] LIM_30      = 16'h7FFF;
  localparam logic [1:0]  GAIN_X1     = 2'h0;
  localparam logic [1:0]  GAIN_X2     = 2'h1;
  localparam logic [1:0]  GAIN_X4     = 2'h2;
  localparam logic [1:0]  GAIN_X8     = 2'h3;
  // -------------------------------------------------------------------
  // serial target
  // -------------------------------------------------------------------
  localparam logic [3:0]  BYTE_BITS   = 4'h8;
  localparam logic [1:0]  IDX_HI      = 2'h0;
  localparam logic [1:0]  IDX_LO      = 2'h1;
  localparam logic [1:0]  IDX_CFG     = 2'h2;
  // capture on the third edge, once the second strap flop holds the pins
  localparam logic [1:0]  STRAP_WAIT  = 2'h3;
  typedef enum logic [2:0] {
    I2C_IDLE  = 3'b000,
    I2C_ADDR  = 3'b001,
    I2C_AACK  = 3'b010,
    I2C_WDATA = 3'b011,
    I2C_WACK  = 3'b100,
    I2C_RDATA = 3'b101,
    I2C_RACK  = 3'b110
  } adcc_i2c_t;
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_RUN  = 1'b1
  } adcc_seq_t;
endpackage : adcc_pkg
`default_nettype wire

// [verilog/adcc_conv_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_conv_seq
  import adcc_pkg::*;
(
  input  wire logic core_clk,   // core clock
  input  wire logic rst,        // sync reset, high
  input  wire logic single_sel, // single-shot mode selected
  input  wire logic start_req,  // host start, idle only
  input  wire logic conv_done,  // converter finished
  output var  logic conv_start, // start pulse to converter
  output var  logic pwr_down,   // converter powered down
  output var  logic busy,       // conversion running
  output var  logic done_ev     // result to be loaded
);
  import adcc_pkg::*;

  adcc_seq_t st_q;
  logic      conv_start_q;
  logic      pwr_down_q;
  wire logic go_idle = (st_q == SEQ_IDLE) && (!single_sel || start_req);

  assign busy       = (st_q == SEQ_RUN);
  assign done_ev    = busy && conv_done;
  assign conv_start = conv_start_q;
  assign pwr_down   = pwr_down_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q         <= SEQ_IDLE;
      conv_start_q <= 1'b0;
      pwr_down_q   <= 1'b1;
    end else begin
      conv_start_q <= 1'b0;
      case (st_q)
        SEQ_IDLE: begin
          if (go_idle) begin
            st_q         <= SEQ_RUN;
            conv_start_q <= 1'b1;
            pwr_down_q   <= 1'b0;
          end
        end
        SEQ_RUN: begin
          if (done_ev && single_sel) begin
            st_q       <= SEQ_IDLE;
            pwr_down_q <= 1'b1;
          end else if (done_ev) begin
            conv_start_q <= 1'b1;
          end
        end
        default: st_q <= SEQ_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_idle_wait: assert property (
    (st_q == SEQ_IDLE) && single_sel && !start_req
    |=> (st_q == SEQ_IDLE) && !conv_start_q)
    else $error("single mode started without request");
  a_cont_next: assert property (
    done_ev && !single_sel |=> conv_start_q && busy)
    else $error("continuous mode did not restart");
  c_single_end: cover property (done_ev && single_sel);
endmodule : adcc_conv_seq
`default_nettype wire

// [verilog/adcc_ctrl.sv]
// Behaviour
// - result clamped to width set by rate
// - results are signed two's complement
// - continuous: load result, restart at once
// - single: idle until host sets flag
// - single done: store, clear flag, power down
// - start write ignored while converting
// - continuous to single: finish, clear, power down
// - power-up reset restores all defaults
// - target only; sda driven low only
// - answer only own three-bit address
// - address from two three-level straps
// - sixteen-bit result register readable
// - result zero until first conversion
// - config register, reset value 80 hex
// - single: write one starts, zero nothing
// - continuous: written flag value discarded
// - continuous: flag low unread, high read
// - single: flag high running, low done
// - mode bit one single, zero continuous
// - rate bits select samples per second
// - gain bits select gain one to eight
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl
  import adcc_pkg::*;
(
  input  wire logic        core_clk,          // 125 MHz core clock
  input  wire logic        rst,               // sync reset, high
  input  wire logic        scl_in,            // serial clock pin
  input  wire logic        sda_in,            // serial data pin level
  output var  logic        sda_out,           // data drive value
  output var  logic        sda_oe,            // high pulls sda low
  input  wire logic        addr_strap_first_lvl,  // strap one level
  input  wire logic        addr_strap_first_flt,  // strap one floating
  input  wire logic        addr_strap_second_lvl, // strap two level
  input  wire logic        addr_strap_second_flt, // strap two floating
  input  wire logic        conv_done,         // conversion finished
  input  wire logic [15:0] conv_data,         // raw signed result
  output var  logic        conv_start,        // start pulse
  output var  logic        pwr_down,          // converter off
  output var  logic        rate_select_hi,    // rate code msb
  output var  logic        rate_select_lo,    // rate code lsb
  output var  logic        gain_select_hi,    // gain code msb
  output var  logic        gain_select_lo     // gain code lsb
);
  import adcc_pkg::*;

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic       scl_d_q;
  logic       sda_d_q;
  logic [3:0] strap_s1_q;
  logic [3:0] strap_s2_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_s_q    <= 2'h3;
      sda_s_q    <= 2'h3;
      scl_d_q    <= 1'b1;
      sda_d_q    <= 1'b1;
      strap_s1_q <= 4'h0;
      strap_s2_q <= 4'h0;
    end else begin
      scl_s_q    <= {scl_s_q[0], scl_in};
      sda_s_q    <= {sda_s_q[0], sda_in};
      scl_d_q    <= scl_s_q[1];
      sda_d_q    <= sda_s_q[1];
      strap_s1_q <= {addr_strap_first_flt, addr_strap_first_lvl,
                     addr_strap_second_flt, addr_strap_second_lvl};
      strap_s2_q <= strap_s1_q;
    end
  end

  wire logic scl_s      = scl_s_q[1];
  wire logic sda_s      = sda_s_q[1];
  wire logic scl_rise   = scl_s && !scl_d_q;
  wire logic scl_fall   = !scl_s && scl_d_q;
  wire logic start_det  = scl_s && scl_d_q && sda_d_q && !sda_s;
  wire logic stop_det   = scl_s && scl_d_q && !sda_d_q && sda_s;

  // -------------------------------------------------------------------
  // strap address, caught once after reset release
  // -------------------------------------------------------------------
  wire logic       f_flt = strap_s2_q[3];
  wire logic       f_lvl = strap_s2_q[2];
  wire logic       s_flt = strap_s2_q[1];
  wire logic       s_lvl = strap_s2_q[0];
  wire logic [2:0] strap_addr = f_flt ? {s_lvl, 2'h3}
                              : {f_lvl, s_flt ? 2'h2 : {1'b0, s_lvl}};
  wire logic       strap_ok = !(f_flt && s_flt);
  logic [1:0] settle_q;
  logic [2:0] addr_q;
  logic       addr_ok_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      settle_q  <= 2'h0;
      addr_q    <= 3'h0;
      addr_ok_q <= 1'b0;
    end else if (settle_q != STRAP_WAIT) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == STRAP_WAIT - 2'h1) begin
        addr_q    <= strap_addr;
        addr_ok_q <= strap_ok; // both floating never answers
      end
    end
  end

  // -------------------------------------------------------------------
  // serial target
  // -------------------------------------------------------------------
  adcc_i2c_t  st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] snap_lo_q;
  logic [1:0] idx_q;
  logic       ack_q;
  logic       oe_q;
  logic       sda_out_q;
  logic [4:0] cfg_q;
  logic       flag_q;
  logic [15:0] res_q;

  wire logic [7:0] cfg_rd  = {flag_q, CFG_PAD, cfg_q};
  wire logic addr_hit = addr_ok_q && (sh_q[7:4] == ADDR_PREFIX)
                        && (sh_q[3:1] == addr_q);
  wire logic byte_end = scl_fall && (cnt_q == BYTE_BITS);
  wire logic in_rx    = (st_q == I2C_ADDR) || (st_q == I2C_WDATA);
  wire logic [7:0] nxt_byte = (idx_q == IDX_HI) ? snap_lo_q : cfg_rd;
  // only the first byte of a write counts; later ones are acked
  wire logic wr_cfg      = (st_q == I2C_WDATA) && byte_end
                           && (idx_q == IDX_HI);
  wire logic rd_low_done = (st_q == I2C_RACK) && scl_rise
                           && (idx_q == IDX_LO);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q      <= I2C_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      snap_lo_q <= 8'h00;
      idx_q     <= IDX_HI;
      ack_q     <= 1'b0;
      oe_q      <= 1'b0;
    end else if (start_det) begin
      st_q  <= I2C_ADDR;
      cnt_q <= 4'h0;
      idx_q <= IDX_HI;
      oe_q  <= 1'b0;
    end else if (stop_det) begin
      st_q <= I2C_IDLE;
      oe_q <= 1'b0;
    end else if (scl_rise) begin
      if (in_rx) begin
        sh_q  <= {sh_q[6:0], sda_s};
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q == I2C_RDATA) begin
        cnt_q <= cnt_q + 4'h1;
      end else if (st_q == I2C_RACK) begin
        ack_q <= !sda_s;
      end
    end else if (scl_fall) begin
      case (st_q)
        I2C_ADDR: begin
          if (byte_end && addr_hit) begin
            st_q <= I2C_AACK;
            oe_q <= 1'b1;
          end else if (byte_end) begin
            st_q <= I2C_IDLE;
          end
        end
        I2C_WDATA: begin
          if (byte_end) begin
            st_q <= I2C_WACK;
            oe_q <= 1'b1;
          end
        end
        I2C_AACK: begin
          cnt_q <= 4'h0;
          if (sh_q[0]) begin
            st_q      <= I2C_RDATA;
            tx_q      <= res_q[15:8];
            snap_lo_q <= res_q[7:0];
            oe_q      <= !res_q[15];
          end else begin
            st_q <= I2C_WDATA;
            oe_q <= 1'b0;
          end
        end
        I2C_WACK: begin
          st_q  <= I2C_WDATA;
          cnt_q <= 4'h0;
          idx_q <= IDX_LO;
          oe_q  <= 1'b0;
        end
        I2C_RDATA: begin
          if (cnt_q == BYTE_BITS) begin
            st_q  <= I2C_RACK;
            cnt_q <= 4'h0;
            oe_q  <= 1'b0;
          end else begin
            tx_q <= {tx_q[6:0], 1'b0};
            oe_q <= !tx_q[6];
          end
        end
        I2C_RACK: begin
          if (ack_q) begin
            st_q  <= I2C_RDATA;
            tx_q  <= nxt_byte;
            oe_q  <= !nxt_byte[7];
            idx_q <= (idx_q == IDX_CFG) ? IDX_CFG : idx_q + 2'h1;
          end else begin
            st_q <= I2C_IDLE;
          end
        end
        default: st_q <= I2C_IDLE;
      endcase
    end
  end

  // open drain: the pad only ever pulls low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_out_q <= 1'b0;
    end else begin
      sda_out_q <= 1'b0;
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe  = oe_q;

  // -------------------------------------------------------------------
  // conversion control
  // -------------------------------------------------------------------
  logic busy;
  logic done_ev;
  wire logic single_sel = cfg_q[SC_BIT];
  // start only from a single-mode write while idle
  wire logic start_req = wr_cfg && sh_q[FLAG_BIT]
                         && sh_q[SC_BIT] && !busy;

  adcc_conv_seq u_seq (
    .core_clk   (core_clk),
    .rst        (rst),
    .single_sel (single_sel),
    .start_req  (start_req),
    .conv_done  (conv_done),
    .conv_start (conv_start),
    .pwr_down   (pwr_down),
    .busy       (busy),
    .done_ev    (done_ev)
  );

  // limit per rate; values are two's complement
  wire logic [1:0]  rate = cfg_q[RATE_HI_BIT:RATE_LO_BIT];
  wire logic [15:0] lim  = (rate == RATE_30)  ? LIM_30
                         : (rate == RATE_60)  ? LIM_60
                         : (rate == RATE_240) ? LIM_240 : LIM_480;
  wire logic over  = $signed(conv_data) > $signed(lim);
  wire logic under = $signed(conv_data) < $signed(~lim);
  wire logic [15:0] clamped = over ? lim : under ? ~lim : conv_data;

  // new result beats a same-cycle read so fresh data never looks stale
  wire logic flag_d = done_ev ? 1'b0
                    : start_req ? 1'b1
                    : (rd_low_done && !single_sel) ? 1'b1
                    : flag_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q  <= CFG_RST[CFG_LOW_W-1:0];
      flag_q <= CFG_RST[FLAG_BIT];
      res_q  <= RES_RST;
    end else begin
      flag_q <= flag_d;
      if (wr_cfg) begin
        cfg_q <= sh_q[CFG_LOW_W-1:0];
      end
      if (done_ev) begin
        res_q <= clamped;
      end
    end
  end

  assign rate_select_hi = cfg_q[RATE_HI_BIT];
  assign rate_select_lo = cfg_q[RATE_LO_BIT];
  assign gain_select_hi = cfg_q[GAIN_HI_BIT];
  assign gain_select_lo = cfg_q[GAIN_LO_BIT];

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_reset_vals: assert property (
    $past(rst) |-> (cfg_rd == CFG_RST) && (res_q == RES_RST))
    else $error("register defaults wrong after reset");
  a_load_flag: assert property (
    done_ev |=> !flag_q)
    else $error("flag not cleared by new result");
  a_single_done: assert property (
    done_ev && single_sel |=> !flag_q && pwr_down && !busy)
    else $error("single conversion end wrong");
  a_result_clamp: assert property (
    done_ev |=> ($signed(res_q) <= $signed($past(lim)))
            && ($signed(res_q) >= $signed(~$past(lim))))
    else $error("result outside rate limit");
  a_start_flag: assert property (
    start_req |=> flag_q && busy && conv_start ##1 !conv_start)
    else $error("single start not taken");
  a_busy_ignore: assert property (
    wr_cfg && busy && !done_ev |=> !conv_start)
    else $error("write started a running conversion");
  a_cont_wr: assert property (
    wr_cfg && !single_sel && !done_ev |=> flag_q == $past(flag_q))
    else $error("continuous write changed flag");
  a_read_sets: assert property (
    rd_low_done && !single_sel && !done_ev |=> flag_q)
    else $error("read did not mark data as read");
  a_addr_miss: assert property (
    (st_q == I2C_ADDR) && byte_end && !addr_hit |=> !sda_oe [*2])
    else $error("acked a foreign address");

  c_single_run: cover property (start_req ##[1:1000] done_ev);
  c_cfg_write:  cover property (wr_cfg);
  c_res_read:   cover property (rd_low_done);
  c_clamped:    cover property (done_ev && (over || under));
endmodule : adcc_ctrl
`default_nettype wire

// [test/adcc_i2c_master.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_i2c_master
  import adcc_pkg::*;
(
  input  wire logic core_clk, // bench clock
  input  wire logic sda_oe,   // device pulls sda low
  output var  logic scl,      // serial clock, idles high
  output wire logic sda       // resolved sda level
);
  import adcc_pkg::*;
  logic m_low;
  // open drain with pull-up: high unless a party pulls low
  assign sda = ~(m_low | sda_oe);
  initial begin
    scl   = 1'h1;
    m_low = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  // one bit: data moves a cycle after scl fall so no false start
  task automatic pulse(input logic low, output logic v);
    tick(1);
    m_low = low;
    tick(4);
    v = sda;
    scl = 1'h1;
    tick(3);
    scl = 1'h0;
  endtask : pulse
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) pulse(~d[i], ack);
    pulse(1'h0, ack);
  endtask : wbyte
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'h0, v);
      d[i] = v;
    end
    pulse(~nack, v);
  endtask : rbyte
  task automatic addr(input logic [2:0] a, input logic rw,
                      output logic ack);
    wbyte({ADDR_PREFIX[3:0], a, rw}, ack);
  endtask : addr
  task automatic start;
    tick(1);
    m_low = 1'h0;
    tick(5);
    scl = 1'h1;
    tick(4);
    m_low = 1'h1;
    tick(4);
    scl = 1'h0;
  endtask : start
  task automatic stop;
    tick(1);
    m_low = 1'h1;
    tick(5);
    scl = 1'h1;
    tick(4);
    m_low = 1'h0;
    tick(4);
  endtask : stop
endmodule : adcc_i2c_master
`default_nettype wire

// [test/adcc_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_test;
  import adcc_pkg::*;
  // long enough for a write and a read, short enough for the start cover
  localparam int LAT = 900;
  logic        core_clk, rst, scl, sda, sda_out, sda_oe;
  logic        st1_lvl, st1_flt, st2_lvl, st2_flt;
  logic        conv_start, pwr_down;
  logic        conv_done = 1'h0;
  logic        rate_hi, rate_lo, gain_hi, gain_lo, a;
  logic [15:0] conv_data, res;
  logic [7:0]  cfg;
  logic [2:0]  dev;
  int          n_errors, checked, n0;
  int          n_start = 0;
  int          cnt = 0;
  logic [15:0] lim [4] = '{LIM_480, LIM_240, LIM_60, LIM_30};
  int          sa [9] = '{0, 0, 0, 1, 1, 1, 2, 2, 2};
  int          sb [9] = '{0, 1, 2, 0, 1, 2, 0, 1, 2};
  logic [2:0]  ea [9] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7,
                          3'h0};

  adcc_ctrl u_dut (
    .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_first_lvl(st1_lvl), .addr_strap_first_flt(st1_flt),
    .addr_strap_second_lvl(st2_lvl), .addr_strap_second_flt(st2_flt),
    .conv_done(conv_done), .conv_data(conv_data),
    .conv_start(conv_start), .pwr_down(pwr_down),
    .rate_select_hi(rate_hi), .rate_select_lo(rate_lo),
    .gain_select_hi(gain_hi), .gain_select_lo(gain_lo));
  adcc_i2c_master u_mst (
    .core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  initial core_clk = 1'h0;
  always #4 core_clk = ~core_clk;
  // ------------------------------------------------------------------
  // converter model
  // ------------------------------------------------------------------
  always @(negedge core_clk) begin
    conv_done <= 1'h0;
    if (conv_start === 1'h1) begin
      n_start <= n_start + 1;
      cnt     <= LAT;
    end else if (cnt != 0) begin
      cnt       <= cnt - 1;
      conv_done <= (cnt == 1);
    end
  end
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic do_reset;
    rst = 1'h1;
    repeat (6) @(negedge core_clk);
    rst = 1'h0;
    repeat (4) @(negedge core_clk);
  endtask : do_reset
  task automatic rd(output logic [15:0] r, output logic [7:0] c);
    u_mst.start();
    u_mst.addr(dev, 1'h1, a);
    chk(16'(a), 16'h0);
    u_mst.rbyte(1'h0, r[15:8]);
    u_mst.rbyte(1'h0, r[7:0]);
    u_mst.rbyte(1'h1, c);
    u_mst.stop();
  endtask : rd
  // the trailing byte is the inverse and must be ignored
  task automatic wr(input logic [7:0] d);
    u_mst.start();
    u_mst.addr(dev, 1'h0, a);
    chk(16'(a), 16'h0);
    u_mst.wbyte(d, a);
    u_mst.wbyte(~d, a);
    u_mst.stop();
  endtask : wr
  task automatic wait_done;
    int i;
    i = 0;
    while (conv_done !== 1'h1 && i < 3000) begin
      @(posedge core_clk);
      i++;
    end
    chk(16'(i < 3000), 16'h1);
    repeat (3) @(negedge core_clk);
  endtask : wait_done
  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    rst = 1'h1;
    {st1_lvl, st1_flt, st2_lvl, st2_flt} = 4'h0;
    conv_data = 16'h0;
    dev = 3'h0;
    n_errors = 0;
    checked = 0;
    do_reset();
    rd(res, cfg);
    chk(res, RES_RST);
    chk(16'(cfg), 16'(CFG_RST));
    chk(16'(sda_out), 16'h0);
    chk(16'(sda_oe), 16'h0);
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      for (int s = 0; s < 2; s++) begin
        conv_data = s ? 16'h8000 : 16'h7FFF;
        if (s == 0) wr({4'h0, 2'(r), 2'(r)});
        n0 = n_start;
        wait_done();
        rd(res, cfg);
        chk(res, s ? ~lim[r] : lim[r]);
        chk(16'(cfg), {8'h0, 4'h8, 2'(r), 2'(r)});
        chk(16'({rate_hi, rate_lo, gain_hi, gain_lo}),
            16'({2'(r), 2'(r)}));
        chk(16'(n_start - n0), 16'h1);
      end
    end
    $display("test rates done");
    conv_data = 16'h1234;
    wr(8'h1F);
    wait_done();
    chk(16'(pwr_down), 16'h1);
    n0 = n_start;
    rd(res, cfg);
    chk(16'(cfg), 16'h001F);
    repeat (200) @(negedge core_clk);
    chk(16'(n_start - n0), 16'h0);
    $display("test mode switch done");
    wr(8'h9F);
    chk(16'(n_start - n0), 16'h1);
    rd(res, cfg);
    chk(16'(cfg), 16'h009F);
    chk(16'(pwr_down), 16'h0);
    wr(8'h9F);
    chk(16'(n_start - n0), 16'h1);
    wait_done();
    chk(16'(pwr_down), 16'h1);
    rd(res, cfg);
    chk(res, 16'h1234);
    chk(16'(cfg), 16'h001F);
    chk(16'(n_start - n0), 16'h1);
    $display("test single done");
    for (int i = 0; i < 9; i++) begin
      {st1_lvl, st1_flt} = {sa[i] == 1, sa[i] == 2};
      {st2_lvl, st2_flt} = {sb[i] == 1, sb[i] == 2};
      do_reset();
      u_mst.start();
      u_mst.addr(ea[i], 1'h0, a);
      u_mst.stop();
      chk(16'(a), 16'(i == 8));
      u_mst.start();
      u_mst.addr(ea[i] ^ 3'h1, 1'h0, a);
      u_mst.stop();
      chk(16'(a), 16'h1);
    end
    $display("test straps done");
    conclude();
  end
  // normal run is near 100 us
  initial begin
    #600000;
    n_errors++;
    conclude();
  end
endmodule : adcc_ctrl_test
`default_nettype wire
